// ---- design/usb_ep_pkg.sv ----
// shared constants and carriers for the low-speed endpoint control block
package usb_ep_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_EP12_CTRL = 6'h20;   // ep12_transmit_control
    localparam logic [5:0] IDX_EN_STALL = 6'h21;    // endpoint_enable_stall_control
    localparam logic [5:0] IDX_EP0_STATUS = 6'h22;  // ep0_receive_status
    localparam logic [5:0] IDX_IRQ_EN = 6'h23;      // interrupt enables
    localparam logic [5:0] IDX_FLAGS = 6'h24;       // event flags and suspend/control_endpoint_force_stall
    localparam logic [5:0] IDX_FLAG_CLR = 6'h25;    // write-one-to-clear strobes
    localparam logic [5:0] IDX_EP12_BUF0 = 6'h28;   // ep12_tx_buffer_byte0
    localparam logic [5:0] IDX_EP12_BUF7 = 6'h2F;   // ep12_tx_buffer_byte7
    localparam logic [5:0] IDX_EP0_BUF0 = 6'h30;    // ep0_data_buffer byte 0
    localparam logic [5:0] IDX_EP0_BUF7 = 6'h37;    // ep0_data_buffer byte 7
    // ep12_transmit_control fields
    localparam int B_TOGGLE = 7;
    localparam int B_SELECT = 6;
    localparam int B_TX_EN = 5;
    localparam int B_WAKEUP = 4;
    // endpoint_enable_stall_control fields
    localparam int B_FIRST_CLR = 7;
    localparam int B_FIRST = 6;
    localparam int B_EN2 = 5;
    localparam int B_EN1 = 4;
    localparam int B_ENDPOINT_TWO_FORCE_STALL = 3;
    localparam int B_ENDPOINT_ONE_FORCE_STALL = 2;
    // ep0_receive_status fields
    localparam int B_RX_TOGGLE = 7;
    localparam int B_SETUP = 6;
    // interrupt enable fields
    localparam int B_IE_TX0 = 0;
    localparam int B_IE_RX0 = 1;
    localparam int B_IE_TX12 = 2;
    localparam int B_IE_EOP = 3;
    // flag and clear-strobe fields (same positions in both registers)
    localparam int B_F_TX0 = 7;
    localparam int B_F_RX0 = 6;
    localparam int B_F_TX12 = 5;
    localparam int B_F_RESUME = 4;
    localparam int B_F_EOP = 3;
    localparam int B_SUSPEND = 1;
    localparam int B_CONTROL_ENDPOINT_FORCE_STALL = 0;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [3:0] EP0_IN_COUNT = 4'h8;     // ep0 IN length, fixed here
    // token identifiers from the packet engine
    localparam logic [1:0] TOK_OUT = 2'h0;
    localparam logic [1:0] TOK_IN = 2'h1;
    localparam logic [1:0] TOK_SETUP = 2'h2;
    // handshake answers
    localparam logic [1:0] RESP_NONE = 2'h0;
    localparam logic [1:0] RESP_NAK = 2'h1;
    localparam logic [1:0] RESP_STALL = 2'h2;
    localparam logic [1:0] RESP_DATA = 2'h3;

    // token decoded by the packet engine
    typedef struct packed {
        logic valid;
        logic [1:0] pid;
        logic [3:0] ep;
    } token_t;

    // answer to one token
    typedef struct packed {
        logic valid;
        logic [1:0] kind;
        logic toggle;
        logic [3:0] count;
    } resp_t;
endpackage

// ---- design/usb_lowspeed_endpoint_ctrl.sv ----
// endpoint control, buffers and bus event flags of a low-speed usb function
//
// The Wishbone register port was decided locally.
module usb_lowspeed_endpoint_ctrl #(
    parameter int BUF_BYTES = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // packet engine side, same clock
    input wire usb_ep_pkg::token_t tok_i,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_done_i,
    input wire logic rx_toggle_i,
    input wire logic host_ack_i,
    input wire logic tx_fetch_i,
    input wire logic [2:0] tx_idx_i,
    output usb_ep_pkg::resp_t resp_o,
    output logic [7:0] tx_byte_o,
    // data line pins
    input wire logic dp_i,
    input wire logic dm_i,
    output logic dp_o,
    output logic dm_o,
    output logic line_oe_o,
    // common usb interrupt request
    output logic usb_irq_o
);
    import usb_ep_pkg::*;
    // the buffers are addressed by three-bit indices
    if (BUF_BYTES != 8) begin : g_check
        $error("BUF_BYTES must be 8");
    end
    // software registers
    logic [7:0] ep12_ctrl_q;           // toggle, select, enable, wakeup, count
    logic [5:2] en_stall_q;            // enables and stalls of ep1/ep2
    logic [3:0] irq_en_q;              // source enables
    logic suspend_q;                   // suspend_control
    logic control_endpoint_force_stall_q;                    // control_endpoint_force_stall
    // hardware flags
    logic tx0_flag_q;                  // ep0_tx_complete_flag
    logic rx0_flag_q;                  // ep0_rx_complete_flag
    logic tx12_flag_q;                 // ep12_tx_complete_flag
    logic resume_flag_q;               // bus_resume_flag
    logic eop_flag_q;                  // end_of_packet_flag
    logic first_flag_q;                // transmit_first_flag
    // ep0 receive status
    logic rx_toggle_q;                 // ep0_received_toggle
    logic setup_q;                     // last ep0 token was SETUP
    logic [3:0] rx_count_q;            // ep0_rx_byte_count, no reset
    logic [3:0] rx_run_q;              // bytes seen in current packet
    // last token, used to route completions
    logic [3:0] last_ep_q;
    logic [1:0] last_pid_q;
    // storage, never reset
    logic [7:0] ep12_buf_q [BUF_BYTES];
    logic [7:0] ep0_tx_buf_q [BUF_BYTES];
    logic [7:0] ep0_rx_buf_q [BUF_BYTES];
    // line synchronisers and history
    logic dp_s1_q, dp_s2_q, dm_s1_q, dm_s2_q;
    logic k_prev_q, se0_prev_q;        // line state one cycle back
    // bus decode
    wire [5:0] idx = wb_adr_i[7:2];
    wire req = wb_cyc_i & wb_stb_i;
    // a write lands on the edge where the master sees ack
    wire wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire [7:0] wd = wb_dat_i[7:0];
    wire wr_ctrl = wr & (idx == IDX_EP12_CTRL);
    wire wr_en_stall = wr & (idx == IDX_EN_STALL);
    wire wr_irq_en = wr & (idx == IDX_IRQ_EN);
    wire wr_flags = wr & (idx == IDX_FLAGS);
    wire wr_clr = wr & (idx == IDX_FLAG_CLR);
    wire ep12_hit = (idx >= IDX_EP12_BUF0) & (idx <= IDX_EP12_BUF7);
    wire ep0_hit = (idx >= IDX_EP0_BUF0) & (idx <= IDX_EP0_BUF7);
    wire [2:0] buf_sel = idx[2:0];
    // token decode
    wire tok_ep0 = tok_i.valid & (tok_i.ep == 4'h0);
    wire tok_ep1 = tok_i.ep == 4'h1;
    wire tok_ep2 = tok_i.ep == 4'h2;
    wire tok_ep12 = tok_i.valid & (tok_ep1 | tok_ep2);
    wire tok_is_in = tok_i.pid == TOK_IN;
    wire tok_setup0 = tok_ep0 & (tok_i.pid == TOK_SETUP);
    wire last_ep12 = (last_ep_q == 4'h1) | (last_ep_q == 4'h2);
    // per-endpoint view of ep1/ep2 controls
    wire ep_en = tok_ep2 ? en_stall_q[B_EN2] : en_stall_q[B_EN1];
    wire ep_stall = tok_ep2 ? en_stall_q[B_ENDPOINT_TWO_FORCE_STALL] : en_stall_q[B_ENDPOINT_ONE_FORCE_STALL];
    wire sel_match = tok_ep2 == ep12_ctrl_q[B_SELECT];
    wire ep12_ready = ep12_ctrl_q[B_TX_EN] & ~tx12_flag_q;
    // answer chosen for an ep1/ep2 token; every branch assigns
    logic [1:0] kind12;
    always_comb begin
        if (!tok_is_in) begin
            // OUT to an IN-only endpoint: stall or ignore
            kind12 = ep_stall ? RESP_STALL : RESP_NONE;
        end else if (!ep_en) begin
            kind12 = RESP_NONE;
        end else if (ep_stall) begin
            kind12 = RESP_STALL;
        // not armed or previous data unclaimed
        end else if (!ep12_ready) begin
            kind12 = RESP_NAK;
        // buffer attached to the other endpoint, select
        end else if (!sel_match) begin
            kind12 = RESP_NAK;
        end else begin
            kind12 = RESP_DATA;
        end
    end
    // answer chosen for an ep0 token; SETUP is always taken
    logic [1:0] kind0;
    always_comb begin
        if (tok_i.pid == TOK_SETUP) begin
            kind0 = RESP_NONE;
        end else if (control_endpoint_force_stall_q) begin
            kind0 = RESP_STALL;
        end else if (tok_is_in) begin
            kind0 = tx0_flag_q ? RESP_NAK : RESP_DATA;
        end else begin
            kind0 = rx0_flag_q ? RESP_NAK : RESP_NONE;
        end
    end
    // event decode
    wire rx0_set = rx_done_i & (last_ep_q == 4'h0);
    // ep0 IN completion on host ACK
    wire tx0_set = host_ack_i & (last_ep_q == 4'h0) & (last_pid_q == TOK_IN);
    // shared flag only once the host acknowledged the data
    wire tx12_set = host_ack_i & last_ep12 & (last_pid_q == TOK_IN);
    wire k_now = dp_s2_q & ~dm_s2_q;
    wire se0_now = ~dp_s2_q & ~dm_s2_q;
    wire j_now = ~dp_s2_q & dm_s2_q;
    // K edge while suspended, gated by suspend, own drive excluded
    wire resume_set = suspend_q & k_now & ~k_prev_q & ~ep12_ctrl_q[B_WAKEUP];
    // end of SE0 back to idle marks end of packet
    wire eop_set = se0_prev_q & j_now;
    // ep0 transmit still flagged when reception completes
    wire first_set = rx0_set & tx0_flag_q;
    // read multiplexer; unmapped and write-only locations read zero
    logic [7:0] rd;
    always_comb begin
        case (idx)
            IDX_EP12_CTRL: rd = ep12_ctrl_q;
            IDX_EN_STALL: rd = {1'b0, first_flag_q, en_stall_q, 2'b00};
            IDX_EP0_STATUS: rd = {rx_toggle_q, setup_q, 2'b00, rx_count_q};
            IDX_IRQ_EN: rd = {4'h0, irq_en_q};
            IDX_FLAGS: rd = {tx0_flag_q, rx0_flag_q, tx12_flag_q, resume_flag_q,
                eop_flag_q, 1'b0, suspend_q, control_endpoint_force_stall_q};
            default: rd = ep0_hit ? ep0_rx_buf_q[buf_sel] : 8'h00;
        endcase
    end
    // bus answer: one wait state, every access acknowledged
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= {24'h00_0000, rd};
        end
    end
    // software control registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ep12_ctrl_q <= CTRL_RESET;
            en_stall_q <= 4'h0;
            irq_en_q <= 4'h0;
            suspend_q <= 1'b0;
        end else begin
            // toggle, count, enable all software owned
            if (wr_ctrl) begin
                ep12_ctrl_q <= wd;
            end
            if (wr_en_stall) begin
                en_stall_q <= wd[5:2];
            end
            if (wr_irq_en) begin
                irq_en_q <= wd[3:0];
            end
            if (wr_flags) begin
                suspend_q <= wd[B_SUSPEND];
            end
        end
    end
    // control endpoint stall: hardware clear beats software write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            control_endpoint_force_stall_q <= 1'b0;
        end else if (tok_setup0) begin
            control_endpoint_force_stall_q <= 1'b0;
        end else if (wr_flags) begin
            control_endpoint_force_stall_q <= wd[B_CONTROL_ENDPOINT_FORCE_STALL];
        end
    end
    // event flags: a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx0_flag_q <= 1'b0;
            rx0_flag_q <= 1'b0;
            tx12_flag_q <= 1'b0;
            resume_flag_q <= 1'b0;
            eop_flag_q <= 1'b0;
            first_flag_q <= 1'b0;
        end else begin
            tx0_flag_q <= tx0_set | (tx0_flag_q & ~(wr_clr & wd[B_F_TX0]));
            rx0_flag_q <= rx0_set | (rx0_flag_q & ~(wr_clr & wd[B_F_RX0]));
            tx12_flag_q <= tx12_set | (tx12_flag_q & ~(wr_clr & wd[B_F_TX12]));
            resume_flag_q <= resume_set | (resume_flag_q & ~(wr_clr & wd[B_F_RESUME]));
            eop_flag_q <= eop_set | (eop_flag_q & ~(wr_clr & wd[B_F_EOP]));
            // write one clears, zero does nothing
            first_flag_q <= first_set | (first_flag_q & ~(wr_en_stall & wd[B_FIRST_CLR]));
        end
    end
    // ep0 receive status; the byte count keeps its value through reset
    always_ff @(posedge core_clk) begin
        if (tok_i.valid & (tok_i.pid != TOK_IN)) begin
            rx_run_q <= COUNT_RESET;
        end else if (rx_byte_valid_i & (rx_run_q != 4'h8)) begin
            rx_run_q <= rx_run_q + 4'h1;
        end
        // count of the last OUT or SETUP packet
        if (rx0_set) begin
            rx_count_q <= rx_run_q;
        end
    end
    // ep0 receive toggle, setup marker and token history
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_toggle_q <= 1'b0;
            setup_q <= 1'b0;
            last_ep_q <= 4'h0;
            last_pid_q <= TOK_OUT;
        end else begin
            // toggle of the last ep0 data packet
            if (rx0_set) begin
                rx_toggle_q <= rx_toggle_i;
            end
            if (tok_ep0) begin
                setup_q <= tok_i.pid == TOK_SETUP;
            end
            if (tok_i.valid) begin
                last_ep_q <= tok_i.ep;
                last_pid_q <= tok_i.pid;
            end
        end
    end
    // byte storage; contents undefined until written
    for (genvar i = 0; i < BUF_BYTES; i++) begin : g_buf
        wire sel_i = buf_sel == 3'(i);
        always_ff @(posedge core_clk) begin
            if (wr & ep12_hit & sel_i) begin
                ep12_buf_q[i] <= wd;
            end
            // ep0 writes fill the transmit side
            if (wr & ep0_hit & sel_i) begin
                ep0_tx_buf_q[i] <= wd;
            end
            // received bytes loaded in arrival order
            if (rx_byte_valid_i & (rx_run_q == 4'(i))) begin
                ep0_rx_buf_q[i] <= rx_byte_i;
            end
        end
    end
    // answer register towards the packet engine
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resp_o <= '0;
            tx_byte_o <= 8'h00;
        end else begin
            resp_o.valid <= tok_i.valid & (tok_ep0 | tok_ep12);
            resp_o.kind <= tok_ep0 ? kind0 : kind12;
            // data toggle, byte count for ep1/ep2
            resp_o.toggle <= tok_ep0 ? 1'b0 : ep12_ctrl_q[B_TOGGLE];
            resp_o.count <= tok_ep0 ? EP0_IN_COUNT : ep12_ctrl_q[3:0];
            // byte source follows the endpoint being served
            if (tx_fetch_i) begin
                tx_byte_o <= last_ep12 ? ep12_buf_q[tx_idx_i] : ep0_tx_buf_q[tx_idx_i];
            end
        end
    end
    // line sampling; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dp_s1_q <= 1'b0;
            dp_s2_q <= 1'b0;
            dm_s1_q <= 1'b1;
            dm_s2_q <= 1'b1;
            k_prev_q <= 1'b0;
            se0_prev_q <= 1'b0;
        end else begin
            dp_s1_q <= dp_i;
            dp_s2_q <= dp_s1_q;
            dm_s1_q <= dm_i;
            dm_s2_q <= dm_s1_q;
            k_prev_q <= k_now;
            se0_prev_q <= se0_now;
        end
    end
    // line drive and common interrupt request
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dp_o <= 1'b0;
            dm_o <= 1'b0;
            line_oe_o <= 1'b0;
            usb_irq_o <= 1'b0;
        end else begin
            // K state for remote wake-up; timing is software's
            line_oe_o <= ep12_ctrl_q[B_WAKEUP];
            dp_o <= ep12_ctrl_q[B_WAKEUP];
            dm_o <= 1'b0;
            // one request; resume has no enable
            usb_irq_o <= resume_flag_q | (eop_flag_q & irq_en_q[B_IE_EOP])
                | (tx0_flag_q & irq_en_q[B_IE_TX0]) | (rx0_flag_q & irq_en_q[B_IE_RX0])
                | (tx12_flag_q & irq_en_q[B_IE_TX12]);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // one IN token for endpoint one or two
    sequence s_ep12_in;
        tok_i.valid && tok_is_in && (tok_ep1 || tok_ep2);
    endsequence
    disabled_no_answer_a: assert property (
        s_ep12_in and !ep_en |=> resp_o.valid && resp_o.kind == RESP_NONE)
        else $error("disabled endpoint answered");
    not_ready_nak_a: assert property (
        s_ep12_in and (ep_en && !ep_stall && !ep12_ready) |=> resp_o.kind == RESP_NAK)
        else $error("unarmed endpoint not NAKed");
    select_mismatch_a: assert property (
        s_ep12_in and (tok_ep2 && ep_en && !ep_stall && ep12_ready
        && !ep12_ctrl_q[B_SELECT]) |=> resp_o.kind == RESP_NAK)
        else $error("ep2 served from ep1 buffer");
    data_toggle_a: assert property (
        s_ep12_in |=> resp_o.toggle == $past(ep12_ctrl_q[B_TOGGLE]))
        else $error("wrong data toggle");
    stall_answer_a: assert property (
        tok_ep12 && ep_stall && (ep_en || !tok_is_in) |=> resp_o.kind == RESP_STALL)
        else $error("stall not sent");
    setup_unstalls_a: assert property (
        tok_setup0 |=> !control_endpoint_force_stall_q && resp_o.kind != RESP_STALL) else $error("setup stalled");
    shared_flag_ack_a: assert property (
        $rose(tx12_flag_q) |-> $past(host_ack_i)) else $error("shared flag without ack");
    first_flag_a: assert property (
        rx0_set && tx0_flag_q |=> first_flag_q) else $error("transmit-first missed");
    resume_gate_a: assert property (
        $rose(resume_flag_q) |-> $past(suspend_q) && !$past(ep12_ctrl_q[B_WAKEUP]))
        else $error("resume flag outside suspend");
    wakeup_drive_a: assert property (
        ep12_ctrl_q[B_WAKEUP] |=> line_oe_o && dp_o && !dm_o) else $error("K state not driven");
    clear_write_a: assert property (
        wr_clr && wd[B_F_TX12] && !tx12_set |=> !tx12_flag_q)
        else $error("shared flag not cleared");
endmodule

// ---- sim/usb_host_model.sv ----
// behavioural low-speed host plus packet engine strobes facing the block
module usb_host_model
    import usb_ep_pkg::*;
(
    // clock
    input wire logic core_clk,
    // strobes into the block
    output usb_ep_pkg::token_t tok,
    output logic host_ack,
    output logic tx_fetch,
    output logic [2:0] tx_idx,
    output logic rx_vld,
    output logic [7:0] rx_byte,
    output logic rx_done,
    output logic rx_tog,
    // data lines; the pull-up on dm leaves idle J
    output logic dp,
    output logic dm
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet bus at time zero
    initial begin
        tok = '0;
        {host_ack, tx_fetch, tx_idx, rx_vld, rx_byte, rx_done, rx_tog, dp, dm} = 18'h00001;
    end
    // token pulse; the answer is settled on return
    task automatic token(input logic [1:0] pid, input logic [3:0] ep);
        @(posedge core_clk) tok <= {1'b1, pid, ep};
        @(posedge core_clk) tok <= '0;
        #1;
    endtask
    // host handshake after our data packet
    task automatic ack();
        @(posedge core_clk) host_ack <= 1'b1;
        @(posedge core_clk) host_ack <= 1'b0;
    endtask
    // byte request; the byte is settled on return
    task automatic fetch(input logic [2:0] i);
        @(posedge core_clk) tx_fetch <= 1'b1;
        tx_idx <= i;
        @(posedge core_clk) tx_fetch <= 1'b0;
        #1;
    endtask
    // two-byte data packet, low byte first; released data shows inverted
    task automatic packet(input logic [15:0] b, input logic t);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk) rx_vld <= 1'b1;
            rx_byte <= b[8*i+:8];
        end
        @(posedge core_clk) rx_vld <= 1'b0;
        rx_byte <= ~rx_byte;
        rx_done <= 1'b1;
        rx_tog <= t;
        @(posedge core_clk) rx_done <= 1'b0;
        rx_tog <= ~t;
    endtask
    // line levels, changed just after an edge
    task automatic line(input logic p, input logic m);
        @(posedge core_clk) dp <= p;
        dm <= m;
    endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the low-speed endpoint control block
module tb_top;
    import usb_ep_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic ack, oe, dpo, dmo, irq, hack, fet, rxv, rxd, rxt, dp, dm;
    logic [31:0] rdat;
    logic [7:0] txb, rxb;
    logic [2:0] idx;
    token_t tok;
    resp_t resp;
    int fail_count = 0;
    int comparisons = 0;
    always #5 core_clk = ~core_clk;
    usb_lowspeed_endpoint_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_ack_o(ack), .wb_dat_o(rdat), .tok_i(tok), .rx_byte_valid_i(rxv), .rx_byte_i(rxb),
        .rx_done_i(rxd), .rx_toggle_i(rxt), .host_ack_i(hack), .tx_fetch_i(fet),
        .tx_idx_i(idx), .resp_o(resp), .tx_byte_o(txb), .dp_i(dp), .dm_i(dm), .dp_o(dpo),
        .dm_o(dmo), .line_oe_o(oe), .usb_irq_o(irq));
    usb_host_model host (.core_clk(core_clk), .tok(tok), .host_ack(hack), .tx_fetch(fet),
        .tx_idx(idx), .rx_vld(rxv), .rx_byte(rxb), .rx_done(rxd), .rx_tog(rxt), .dp(dp), .dm(dm));
    // verdict and end of run
    task automatic tally_and_finish();
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one comparison of an eight-bit value
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // classic single cycle; ends at the edge that samples ack, bounded wait
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {a, 2'b00};
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) begin
            fail_count++;
            tally_and_finish();
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        wb(1'b1, a, d, x);
    endtask
    task automatic rd(input string nm, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(nm, e, q);
    endtask
    // token, then the answer; toggle and count only matter for data
    task automatic tk(input logic [1:0] p, input logic [3:0] ep, input logic [7:0] e);
        host.token(p, ep);
        chk("resp", e, (e[6:5] == RESP_DATA) ? resp : {resp[7:5], 5'h0});
    endtask
    task automatic t_reset();
        rd("ctrl", IDX_EP12_CTRL, 8'h00); // cleared
        rd("en_stall", IDX_EN_STALL, 8'h00); // cleared
        rd("unmapped", 6'h3F, 8'h00);
    endtask
    // shared buffer on endpoint one: data, completion, nak and flag clear
    task automatic t_ep1();
        tk(TOK_IN, 4'h1, 8'h80); // disabled
        for (int i = 0; i < 8; i++) wr(IDX_EP12_BUF0 + 6'(i), 8'h10 + 8'(i));
        wr(IDX_EN_STALL, 8'h10); // enable first
        wr(IDX_EP12_CTRL, 8'hA5); // armed
        tk(TOK_IN, 4'h1, 8'hF5); // data1
        host.fetch(3'h3);
        chk("txbyte", 8'h13, txb); // buffer
        rd("flags", IDX_FLAGS, 8'h00); // before ack
        host.ack();
        rd("flags", IDX_FLAGS, 8'h20); // set
        tk(TOK_IN, 4'h1, 8'hA0); // flag nak
        wr(IDX_FLAG_CLR, 8'h00);
        rd("flags", IDX_FLAGS, 8'h20); // zero ignored
        wr(IDX_FLAG_CLR, 8'h20);
        rd("flags", IDX_FLAGS, 8'h00); // cleared
        wr(IDX_EP12_CTRL, 8'h85);
        tk(TOK_IN, 4'h1, 8'hA0); // enable off
    endtask
    // endpoint two: select mismatch, data0 and stall
    task automatic t_ep2();
        wr(IDX_EN_STALL, 8'h20);
        wr(IDX_EP12_CTRL, 8'h23);
        tk(TOK_IN, 4'h2, 8'hA0); // select nak
        wr(IDX_EP12_CTRL, 8'h63);
        tk(TOK_IN, 4'h2, 8'hE3); // data0
        wr(IDX_EN_STALL, 8'h28);
        tk(TOK_IN, 4'h2, 8'hC0); // in stalled
        tk(TOK_OUT, 4'h2, 8'hC0); // out stalled
        tk(TOK_IN, 4'h1, 8'h80); // off
    endtask
    // control endpoint: setup over stall, receive status, transmit-first
    task automatic t_ep0();
        wr(IDX_FLAGS, 8'h01);
        tk(TOK_SETUP, 4'h0, 8'h80); // accepted
        host.packet(16'h5CA1, 1'b0);
        rd("status", IDX_EP0_STATUS, 8'h42);
        rd("buf0", IDX_EP0_BUF0, 8'hA1); // received
        rd("buf1", IDX_EP0_BUF0 + 6'h1, 8'h5C); // received
        rd("flags", IDX_FLAGS, 8'h40); // stall gone
        wr(IDX_FLAG_CLR, 8'h40);
        tk(TOK_IN, 4'h0, 8'hE8);
        host.ack();
        rd("flags", IDX_FLAGS, 8'h80); // transmit
        tk(TOK_OUT, 4'h0, 8'h80);
        host.packet(16'h0201, 1'b1);
        rd("status", IDX_EP0_STATUS, 8'h82); // out data1
        rd("en_stall", IDX_EN_STALL, 8'h68); // first set
        wr(IDX_EN_STALL, 8'h80);
        rd("en_stall", IDX_EN_STALL, 8'h00); // cleared
        wr(IDX_FLAG_CLR, 8'hF8);
    endtask
    // remote wakeup, resume while suspended, end of packet
    task automatic t_line();
        wr(IDX_FLAGS, 8'h02);
        wr(IDX_EP12_CTRL, 8'h10); // hold kept short to bound the run
        @(posedge core_clk) #1;
        chk("pins", 8'h06, {5'h0, oe, dpo, dmo}); // drives k
        host.line(1'b1, 1'b0);
        repeat (6) @(posedge core_clk);
        rd("flags", IDX_FLAGS, 8'h02); // own k while suspended, no resume
        wr(IDX_EP12_CTRL, 8'h00);
        host.line(1'b0, 1'b1);
        wr(IDX_FLAGS, 8'h00);
        host.line(1'b1, 1'b0);
        repeat (6) @(posedge core_clk);
        rd("flags", IDX_FLAGS, 8'h00); // awake
        host.line(1'b0, 1'b1);
        wr(IDX_FLAGS, 8'h02);
        host.line(1'b1, 1'b0);
        repeat (6) @(posedge core_clk);
        rd("flags", IDX_FLAGS, 8'h12); // resume
        chk("irq", 8'h01, {7'h0, irq}); // ungated
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_FLAG_CLR, 8'h10);
        host.line(1'b0, 1'b0);
        repeat (3) @(posedge core_clk);
        host.line(1'b0, 1'b1);
        repeat (6) @(posedge core_clk);
        rd("flags", IDX_FLAGS, 8'h08); // eop
        chk("irq", 8'h00, {7'h0, irq}); // gated
        wr(IDX_IRQ_EN, 8'h08);
        repeat (2) @(posedge core_clk);
        chk("irq", 8'h01, {7'h0, irq}); // enabled
    endtask
    // reset in mid-run: control state cleared, receive count kept
    task automatic t_rerun();
        wr(IDX_EP12_CTRL, 8'hEF);
        @(posedge core_clk) sys_rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd("ctrl", IDX_EP12_CTRL, 8'h00); // cleared again
        rd("status", IDX_EP0_STATUS, 8'h02); // count kept
    endtask
    // main sequence; reset held four edges
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_ep1();
        t_ep2();
        t_ep0();
        t_rerun();
        t_line();
        tally_and_finish();
    end
endmodule
